// file: logic/pmi_defines.svh
// Constants for the indirect management register block: offsets, fields,
// reset values and timing counts.
// Assumes a 40 MHz system clock and a five-bit management register address.
`ifndef PMI_DEFINES_SVH
`define PMI_DEFINES_SVH

`define PMI_ADDR_EXT_CTRL   5'h0D
`define PMI_ADDR_EXT_DATA   5'h0E
`define PMI_ADDR_GIG_ABIL   5'h0F
`define PMI_ADDR_PHY_CTRL   5'h10

`define PMI_FN_ADDR         2'b00
`define PMI_FN_DATA         2'b01
`define PMI_FN_INC_RW       2'b10
`define PMI_FN_INC_WR       2'b11

`define PMI_DEVSEL_EXT      5'h1F
`define PMI_EXTCR_RST       16'h0000
`define PMI_EXTCR_WMASK     16'hC01F
`define PMI_GIG_ABIL_VAL    16'h3000
`define PMI_PHY_CONTROL_RST       16'h5008
`define PMI_PHY_CONTROL_WMASK     16'hC790
`define PMI_PHY_CONTROL_FIXED     16'h1008

`define PMI_PCR_FORCE_LINK  10
`define PMI_PCR_DEEP_PD_EN  7
`define PMI_PCR_CLK125_DIS  4

`define PMI_PS_NORMAL       2'b00
`define PMI_PS_IEEE         2'b01
`define PMI_PS_ACTIVE       2'b10
`define PMI_PS_PASSIVE      2'b11

`define PMI_EXT_BASE        16'h0020
`define PMI_EXT_LIMIT       16'h0060
`define PMI_EXT_DEPTH       64

`define PMI_PREAMBLE_LEN    6'd32
`define PMI_OP_WRITE        2'b01
`define PMI_OP_READ         2'b10

`define PMI_CLK_HZ          40000000
`define PMI_LINK_PULSE_MS   1400
`define PMI_LINK_PULSE_CYC  ((`PMI_CLK_HZ / 1000) * `PMI_LINK_PULSE_MS)

`endif

// file: logic/pmi_pkg.sv
// Types shared by the indirect management register block.
// Assumes pmi_defines.svh supplies the numeric constants.
`default_nettype none

package pmi_pkg;

  // Serial management frame position
  typedef enum logic [2:0] {
    PMI_IDLE  = 3'b000,
    PMI_START = 3'b001,
    PMI_HDR   = 3'b010,
    PMI_TA1   = 3'b011,
    PMI_TA2   = 3'b100,
    PMI_RDAT  = 3'b101,
    PMI_WDAT  = 3'b110
  } pmi_state_t;

  // Frame header after start bits
  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] regad;
  } pmi_hdr_t;

  // Power state outputs
  typedef struct packed {
    logic passive_sleep;
    logic active_sleep;
    logic ieee_pd;
    logic pll_pd;
    logic power_down;
    logic deep_power_down;
  } pmi_pwr_t;

endpackage : pmi_pkg

`default_nettype wire

// file: logic/pmi_regs.sv
// Management register logic: serial management slave, indirect access pair,
// gigabit ability register and part of the PHY control register.
// Assumes mdc, mdio_i and the pins arrive asynchronously; core status inputs
// (speed, MAC mode, line link, basic control power-down) are on clk_sys.
// Contract
// - Function field 00 targets the pointer, 01 data without pointer change
// - Function 10 increments pointer after every data read or write
// - Function 11 increments pointer after writes only, reads leave it
// - Indirect accesses ignored while device select differs from 11111
// - Reserved bits discard writes and read zero
// - Address/data maps to pointer for 00, else to pointed register
// - Gigabit ability read-only: X bits read 0, T bits read 1
// - FIFO depth encodings 11=8, 10=6, 01=4, 00=3
// - FIFO depth only applies at 1000BASE-T with GMII
// - Force link good bit reports link good regardless of line
// - Power save 11 is passive sleep, 00 normal operation
// - Power save 10 active sleep, pulse every 1.4 s, wake on partner
// - Power save 01 powers down blocks, PLL too when clock enabled
// - Deep power-down enable turns power-down requests into deep power-down
// - Indirect pair reaches extended registers above address 0x001F; the code holds only 0x0020 to 0x005F
`timescale 1ns/1ps
`default_nettype none
`include "pmi_defines.svh"

module pmi_regs
  import pmi_pkg::*;
#(
  parameter int unsigned LINK_PULSE_CYC = `PMI_LINK_PULSE_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       mdc,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe,
  input  wire logic [4:0] phy_addr_strap,
  input  wire logic       pd_pin,
  input  wire logic       partner_detect,
  input  wire logic       basic_mode_control_pd,
  input  wire logic       speed_is_1000,
  input  wire logic       mac_if_gmii,
  input  wire logic       line_link_ok,
  output logic [3:0]      tx_fifo_depth_q,
  output logic            link_good_q,
  output logic            link_pulse_q,
  output pmi_pwr_t        pwr_q
);

  logic [8:0]  sync1_q, sync2_q;
  logic        mdc_prev_q, mdc_rise, mdio_s, pd_pin_s, partner_s;
  logic [4:0]  phy_addr_s, acc_reg_q;
  pmi_state_t  state_q;
  logic [5:0]  cnt_q;
  logic [11:0] hdr_sr_q;
  pmi_hdr_t    hdr_c;
  logic [15:0] sr_q, wr_val_q, ext_ctrl_q, ext_ptr_q, phy_ctrl_q, rd_val_c, ptr_off;
  logic        wr_go_q, rd_go_q, sel_ok, data_acc;
  logic [15:0] ext_mem [0:`PMI_EXT_DEPTH-1];
  logic [1:0]  fn;
  logic [31:0] pulse_cnt_q;

  // True when the pointer lands in the extended register window
  function automatic logic ext_hit(input logic [15:0] p);
    ext_hit = (p >= `PMI_EXT_BASE) && (p < `PMI_EXT_LIMIT);
  endfunction : ext_hit

  // Depth in bytes or nibbles for a depth code
  function automatic logic [3:0] fifo_depth(input logic [1:0] code);
    case (code)
      2'b11:   fifo_depth = 4'h8;
      2'b10:   fifo_depth = 4'h6;
      2'b01:   fifo_depth = 4'h4;
      default: fifo_depth = 4'h3;
    endcase
  endfunction : fifo_depth

  // Two-stage synchronisers for every asynchronous input
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q    <= 9'h000;
      sync2_q    <= 9'h000;
      mdc_prev_q <= 1'b0;
    end else begin
      sync1_q    <= {mdc, mdio_i, pd_pin, partner_detect, phy_addr_strap};
      sync2_q    <= sync1_q;
      mdc_prev_q <= sync2_q[8];
    end
  end

  assign mdc_rise   = sync2_q[8] & ~mdc_prev_q;
  assign mdio_s     = sync2_q[7];
  assign pd_pin_s   = sync2_q[6];
  assign partner_s  = sync2_q[5];
  assign phy_addr_s = sync2_q[4:0];
  assign hdr_c      = pmi_hdr_t'(hdr_sr_q);
  assign fn         = ext_ctrl_q[15:14];
  assign sel_ok     = (ext_ctrl_q[4:0] == `PMI_DEVSEL_EXT);
  assign ptr_off    = ext_ptr_q - `PMI_EXT_BASE;
  assign data_acc   = (acc_reg_q == `PMI_ADDR_EXT_DATA) && sel_ok && (fn != `PMI_FN_ADDR);

  // Read value for the addressed register
  always_comb begin
    rd_val_c = 16'h0000;
    case (hdr_c.regad)
      `PMI_ADDR_EXT_CTRL: rd_val_c = ext_ctrl_q & `PMI_EXTCR_WMASK;
      `PMI_ADDR_EXT_DATA: begin
        if (!sel_ok) begin
          rd_val_c = 16'h0000;
        end else if (fn == `PMI_FN_ADDR) begin
          rd_val_c = ext_ptr_q;
        end else if (ext_hit(ext_ptr_q)) begin
          rd_val_c = ext_mem[ptr_off[5:0]];
        end
      end
      `PMI_ADDR_GIG_ABIL: rd_val_c = `PMI_GIG_ABIL_VAL;
      `PMI_ADDR_PHY_CTRL: rd_val_c = phy_ctrl_q;
      default:            rd_val_c = 16'h0000;
    endcase
  end

  // Serial frame engine, advanced on each sampled clock rising edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q   <= PMI_IDLE;
      cnt_q     <= 6'd0;
      hdr_sr_q  <= 12'h000;
      sr_q      <= 16'h0000;
      mdio_o    <= 1'b0;
      mdio_oe   <= 1'b0;
      wr_go_q   <= 1'b0;
      rd_go_q   <= 1'b0;
      acc_reg_q <= 5'h00;
      wr_val_q  <= 16'h0000;
    end else begin
      wr_go_q <= 1'b0;
      rd_go_q <= 1'b0;
      if (mdc_rise) begin
        case (state_q)
          PMI_IDLE: begin
            if (mdio_s) begin
              cnt_q <= (cnt_q == `PMI_PREAMBLE_LEN) ? cnt_q : cnt_q + 6'd1;
            end else begin
              if (cnt_q == `PMI_PREAMBLE_LEN) begin
                state_q <= PMI_START;
              end
              cnt_q <= 6'd0;
            end
          end
          PMI_START: begin
            state_q <= mdio_s ? PMI_HDR : PMI_IDLE;
            cnt_q   <= 6'd0;
          end
          PMI_HDR: begin
            hdr_sr_q <= {hdr_sr_q[10:0], mdio_s};
            cnt_q    <= cnt_q + 6'd1;
            if (cnt_q == 6'd11) begin
              state_q <= PMI_TA1;
              cnt_q   <= 6'd0;
            end
          end
          PMI_TA1: begin
            acc_reg_q <= hdr_c.regad;
            if (hdr_c.phy != phy_addr_s) begin
              state_q <= PMI_IDLE;
            end else if (hdr_c.op == `PMI_OP_READ) begin
              mdio_oe <= 1'b1; // Turnaround zero
              mdio_o  <= 1'b0;
              sr_q    <= rd_val_c;
              state_q <= PMI_RDAT;
            end else if (hdr_c.op == `PMI_OP_WRITE) begin
              state_q <= PMI_TA2;
            end else begin
              state_q <= PMI_IDLE;
            end
          end
          PMI_TA2: state_q <= PMI_WDAT;
          PMI_RDAT: begin
            if (cnt_q == 6'd16) begin
              mdio_oe <= 1'b0;
              mdio_o  <= 1'b0;
              rd_go_q <= 1'b1; // Read completes here
              state_q <= PMI_IDLE;
              cnt_q   <= 6'd0;
            end else begin
              mdio_o <= sr_q[15];
              sr_q   <= {sr_q[14:0], 1'b0};
              cnt_q  <= cnt_q + 6'd1;
            end
          end
          PMI_WDAT: begin
            sr_q  <= {sr_q[14:0], mdio_s};
            cnt_q <= cnt_q + 6'd1;
            if (cnt_q == 6'd15) begin
              wr_val_q <= {sr_q[14:0], mdio_s};
              wr_go_q  <= 1'b1;
              state_q  <= PMI_IDLE;
              cnt_q    <= 6'd0;
            end
          end
          default: begin
            state_q <= PMI_IDLE;
            cnt_q   <= 6'd0;
          end
        endcase
      end
    end
  end

  // Indirect control, pointer and PHY control registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_ctrl_q <= `PMI_EXTCR_RST;
      ext_ptr_q  <= 16'h0000;
      phy_ctrl_q <= `PMI_PHY_CONTROL_RST;
    end else begin
      if (phy_ctrl_q[9:8] == `PMI_PS_ACTIVE && partner_s) begin
        phy_ctrl_q[9:8] <= `PMI_PS_NORMAL; // Wake up on partner
      end
      if (wr_go_q) begin
        case (acc_reg_q)
          `PMI_ADDR_EXT_CTRL: ext_ctrl_q <= wr_val_q & `PMI_EXTCR_WMASK;
          `PMI_ADDR_PHY_CTRL: phy_ctrl_q <= (wr_val_q & `PMI_PHY_CONTROL_WMASK) | `PMI_PHY_CONTROL_FIXED;
          `PMI_ADDR_EXT_DATA: begin
            if (sel_ok && fn == `PMI_FN_ADDR) begin
              ext_ptr_q <= wr_val_q;
            end else if (data_acc && fn != `PMI_FN_DATA) begin
              ext_ptr_q <= ext_ptr_q + 16'h0001;
            end
          end
          default: ;
        endcase
      end
      if (rd_go_q && data_acc && fn == `PMI_FN_INC_RW) begin
        ext_ptr_q <= ext_ptr_q + 16'h0001;
      end
    end
  end

  // Extended register storage, written only through the indirect pair
  always_ff @(posedge clk_sys) begin
    if (wr_go_q && data_acc && ext_hit(ext_ptr_q)) begin
      ext_mem[ptr_off[5:0]] <= wr_val_q;
    end
  end

  // Datapath settings and link state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_fifo_depth_q <= 4'h0;
      link_good_q     <= 1'b0;
    end else begin
      tx_fifo_depth_q <= (speed_is_1000 && mac_if_gmii) ?
                         fifo_depth(phy_ctrl_q[15:14]) : 4'h0;
      link_good_q     <= phy_ctrl_q[`PMI_PCR_FORCE_LINK] | line_link_ok;
    end
  end

  // Power state decode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr_q <= '0;
    end else begin
      pwr_q.passive_sleep   <= (phy_ctrl_q[9:8] == `PMI_PS_PASSIVE);
      pwr_q.active_sleep    <= (phy_ctrl_q[9:8] == `PMI_PS_ACTIVE);
      pwr_q.ieee_pd         <= (phy_ctrl_q[9:8] == `PMI_PS_IEEE);
      pwr_q.pll_pd          <= (phy_ctrl_q[9:8] == `PMI_PS_IEEE) &&
                               !phy_ctrl_q[`PMI_PCR_CLK125_DIS];
      pwr_q.power_down      <= (pd_pin_s | basic_mode_control_pd) &&
                               !phy_ctrl_q[`PMI_PCR_DEEP_PD_EN];
      pwr_q.deep_power_down <= (pd_pin_s | basic_mode_control_pd) &&
                               phy_ctrl_q[`PMI_PCR_DEEP_PD_EN];
    end
  end

  // Wake pulse timer while in active sleep; restarts whenever the mode is left
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulse_cnt_q  <= 32'h0000_0000;
      link_pulse_q <= 1'b0;
    end else if (phy_ctrl_q[9:8] != `PMI_PS_ACTIVE || pulse_cnt_q == LINK_PULSE_CYC - 1) begin
      pulse_cnt_q  <= 32'h0000_0000;
      link_pulse_q <= (phy_ctrl_q[9:8] == `PMI_PS_ACTIVE);
    end else begin
      pulse_cnt_q  <= pulse_cnt_q + 32'h0000_0001;
      link_pulse_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Checks
  ptr_load_a: assert property (wr_go_q && acc_reg_q == `PMI_ADDR_EXT_DATA && sel_ok
    && fn == `PMI_FN_ADDR |=> ext_ptr_q == $past(wr_val_q))
    else $error("pointer not loaded");
  ptr_hold_a: assert property ((wr_go_q || rd_go_q) && data_acc && fn == `PMI_FN_DATA
    |=> $stable(ext_ptr_q))
    else $error("pointer moved in plain data mode");
  inc_read_a: assert property (rd_go_q && data_acc && fn == `PMI_FN_INC_RW
    |=> ext_ptr_q == $past(ext_ptr_q) + 16'h0001)
    else $error("pointer not incremented after read");
  wr_only_a: assert property (rd_go_q && data_acc && fn == `PMI_FN_INC_WR
    |=> $stable(ext_ptr_q))
    else $error("pointer moved on read in write-only mode");
  wr_inc_a: assert property (wr_go_q && data_acc && fn == `PMI_FN_INC_WR
    |=> ext_ptr_q == $past(ext_ptr_q) + 16'h0001)
    else $error("pointer not incremented after write");
  sel_gate_a: assert property ((wr_go_q || rd_go_q) && acc_reg_q == `PMI_ADDR_EXT_DATA
    && !sel_ok |=> $stable(ext_ptr_q))
    else $error("access with wrong device select took effect");
  rsvd_zero_a: assert property (ext_ctrl_q[13:5] == 9'h000)
    else $error("reserved control bits set");
  gig_read_a: assert property (state_q == PMI_TA1 && mdc_rise && hdr_c.op == `PMI_OP_READ
    && hdr_c.phy == phy_addr_s && hdr_c.regad == `PMI_ADDR_GIG_ABIL
    |=> sr_q == `PMI_GIG_ABIL_VAL && mdio_oe)
    else $error("gigabit ability value wrong");
  fifo_off_a: assert property (!(speed_is_1000 && mac_if_gmii)
    |=> tx_fifo_depth_q == 4'h0)
    else $error("fifo depth applied outside gigabit GMII");
  force_link_a: assert property (phy_ctrl_q[`PMI_PCR_FORCE_LINK] |=> link_good_q)
    else $error("forced link not good");
  passive_a: assert property (phy_ctrl_q[9:8] == `PMI_PS_PASSIVE ##1
    phy_ctrl_q[9:8] == `PMI_PS_PASSIVE |-> pwr_q.passive_sleep && !link_pulse_q)
    else $error("passive sleep not entered");
  deep_pd_a: assert property (phy_ctrl_q[`PMI_PCR_DEEP_PD_EN] && basic_mode_control_pd
    |=> pwr_q.deep_power_down && !pwr_q.power_down)
    else $error("deep power-down not entered");

  rd_frame_c: cover property (rd_go_q && acc_reg_q == `PMI_ADDR_EXT_DATA);
  wr_frame_c: cover property (wr_go_q && data_acc && fn == `PMI_FN_INC_RW);
  pulse_c:    cover property (link_pulse_q);

endmodule : pmi_regs

`default_nettype wire

// file: dv/pmi_mgmt_model.sv
// Station management controller model: sends serial management frames.
// Assumes the bench resolves the mdio wire from both drivers, pull-up high.
`timescale 1ns/1ps
`default_nettype none

module pmi_mgmt_model (
  input  wire logic clk_sys,
  input  wire logic mdio_w,
  output logic      mdc,
  output logic      mdio_d,
  output logic      mdio_en
);
  // Clock parked low and line released outside frames
  initial begin
    mdc     = 1'b0;
    mdio_d  = 1'b0;
    mdio_en = 1'b0;
  end

  // One bit: data set at the fall, sampled just before the rise
  task automatic one_bit(input logic b, input logic drv, output logic s);
    mdio_en <= drv;
    mdio_d  <= b;
    repeat (4) @(posedge clk_sys);
    s = mdio_w;
    mdc <= 1'b1;
    repeat (4) @(posedge clk_sys);
    mdc <= 1'b0;
  endtask : one_bit

  // Whole frame; on reads the line is released from turnaround on
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    logic        wop;
    hdr = {2'b01, op, phy, ra};
    wop = (op != 2'b10);
    @(posedge clk_sys);
    repeat (32) one_bit(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) one_bit(hdr[i], 1'b1, s);
    one_bit(1'b1, wop, s);
    one_bit(1'b0, wop, s);
    for (int i = 15; i >= 0; i--) begin
      one_bit(wd[i], wop, s);
      rd[i] = s;
    end
    mdio_en <= 1'b0;
    repeat (12) @(posedge clk_sys);
  endtask : frame
endmodule : pmi_mgmt_model
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the management register block.
// Assumes the controller model sends frames; expectations are literals, stimulus values, expressions of them or come from functions.
`timescale 1ns/1ps
`default_nettype none
`include "pmi_defines.svh"

module testbench;
  import pmi_pkg::*;
  localparam int PULSE = 50;
  logic clk_sys, rst, mdc, mdio_d, mdio_en, mdio_o, mdio_oe, mdio_w;
  logic [4:0] strap;
  logic       pd_pin, partner_detect, bmc_pd, speed_is_1000, mac_if_gmii, line_link_ok;
  logic [3:0] tx_fifo_depth_q;
  logic       link_good_q, link_pulse_q;
  pmi_pwr_t   pwr_q;
  int         err_count, compares, cycles, n;

  pmi_regs #(.LINK_PULSE_CYC(PULSE)) pmi_regs_inst (
    .clk_sys(clk_sys), .rst(rst), .mdc(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .phy_addr_strap(strap), .pd_pin(pd_pin),
    .partner_detect(partner_detect), .basic_mode_control_pd(bmc_pd),
    .speed_is_1000(speed_is_1000), .mac_if_gmii(mac_if_gmii),
    .line_link_ok(line_link_ok), .tx_fifo_depth_q(tx_fifo_depth_q),
    .link_good_q(link_good_q), .link_pulse_q(link_pulse_q), .pwr_q(pwr_q));

  pmi_mgmt_model pmi_mgmt_model_inst (
    .clk_sys(clk_sys), .mdio_w(mdio_w), .mdc(mdc), .mdio_d(mdio_d), .mdio_en(mdio_en));

  // Shared wire with pull-up
  assign mdio_w = mdio_oe ? mdio_o : (mdio_en ? mdio_d : 1'b1);

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Hang guard: some 75 frames of about 530 cycles fit well below
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      tally_and_finish();
    end
  end

  function automatic logic [15:0] depth(input int c);
    case (c)
      0: return 16'h0003;
      1: return 16'h0004;
      2: return 16'h0006;
      default: return 16'h0008;
    endcase
  endfunction : depth

  function automatic pmi_pwr_t exp_pwr(input logic [15:0] cr, input logic pd);
    pmi_pwr_t e;
    e.passive_sleep   = (cr[9:8] == 2'b11);
    e.active_sleep    = (cr[9:8] == 2'b10);
    e.ieee_pd         = (cr[9:8] == 2'b01);
    e.pll_pd          = e.ieee_pd & ~cr[4];
    e.power_down      = pd & ~cr[7];
    e.deep_power_down = pd & cr[7];
    return e;
  endfunction : exp_pwr

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] r;
    pmi_mgmt_model_inst.frame(`PMI_OP_WRITE, strap, ra, d, r);
  endtask : wr

  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] r;
    pmi_mgmt_model_inst.frame(`PMI_OP_READ, strap, ra, 16'h0000, r);
    chk(r, e);
  endtask : rd

  // Select the extended set, load the pointer, then pick the function
  task automatic setp(input logic [15:0] ptr, input logic [1:0] fn);
    wr(`PMI_ADDR_EXT_CTRL, 16'h001F);
    wr(`PMI_ADDR_EXT_DATA, ptr);
    wr(`PMI_ADDR_EXT_CTRL, {fn, 14'h001F});
  endtask : setp

  task automatic tally_and_finish();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    logic [15:0] p, w0, w1, w2, cr;
    void'($urandom(32'h54de_c910));
    rst = 1'b1;
    strap = 5'($urandom);
    {pd_pin, partner_detect, bmc_pd, speed_is_1000, mac_if_gmii, line_link_ok} = '0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(`PMI_ADDR_EXT_CTRL, 16'h0000);
    rd(`PMI_ADDR_PHY_CTRL, 16'h5008);
    rd(5'h05, 16'h0000);
    wr(`PMI_ADDR_GIG_ABIL, 16'hFFFF);
    rd(`PMI_ADDR_GIG_ABIL, 16'h3000);
    wr(`PMI_ADDR_EXT_CTRL, 16'hFFFF);
    rd(`PMI_ADDR_EXT_CTRL, 16'hC01F);
    // Indirect pair across all four functions
    p = 16'h0020 + 16'($urandom_range(56, 0));
    w0 = 16'($urandom);
    w1 = 16'($urandom);
    w2 = 16'($urandom);
    setp(p, 2'b00);
    rd(`PMI_ADDR_EXT_DATA, p);
    wr(`PMI_ADDR_EXT_CTRL, 16'h401F);
    wr(`PMI_ADDR_EXT_DATA, w0);
    rd(`PMI_ADDR_EXT_DATA, w0);
    wr(`PMI_ADDR_EXT_CTRL, 16'h801F);
    wr(`PMI_ADDR_EXT_DATA, w1);
    wr(`PMI_ADDR_EXT_DATA, w2);
    wr(`PMI_ADDR_EXT_CTRL, 16'h001F);
    rd(`PMI_ADDR_EXT_DATA, p + 16'h0002);
    setp(p, 2'b10);
    rd(`PMI_ADDR_EXT_DATA, w1);
    rd(`PMI_ADDR_EXT_DATA, w2);
    setp(p, 2'b11);
    rd(`PMI_ADDR_EXT_DATA, w1);
    rd(`PMI_ADDR_EXT_DATA, w1);
    wr(`PMI_ADDR_EXT_DATA, w0);
    rd(`PMI_ADDR_EXT_DATA, w2);
    // Foreign device select: nothing moves
    wr(`PMI_ADDR_EXT_CTRL, 16'h001E);
    wr(`PMI_ADDR_EXT_DATA, ~p);
    wr(`PMI_ADDR_EXT_CTRL, 16'h401E);
    wr(`PMI_ADDR_EXT_DATA, ~w2);
    rd(`PMI_ADDR_EXT_DATA, 16'h0000);
    wr(`PMI_ADDR_EXT_CTRL, 16'h001F);
    rd(`PMI_ADDR_EXT_DATA, p + 16'h0001);
    wr(`PMI_ADDR_EXT_CTRL, 16'h401F);
    rd(`PMI_ADDR_EXT_DATA, w2);
    // PHY control read-back
    cr = 16'($urandom);
    wr(`PMI_ADDR_PHY_CTRL, cr);
    rd(`PMI_ADDR_PHY_CTRL, (cr & 16'hC790) | 16'h1008);
    // Foreign address and reserved op code: frames dropped, line left to the pull-up
    pmi_mgmt_model_inst.frame(`PMI_OP_WRITE, ~strap, `PMI_ADDR_PHY_CTRL, ~cr, w1);
    pmi_mgmt_model_inst.frame(2'b11, strap, `PMI_ADDR_PHY_CTRL, ~cr, w1);
    pmi_mgmt_model_inst.frame(`PMI_OP_READ, ~strap, `PMI_ADDR_PHY_CTRL, 16'h0000, w1);
    chk(w1, 16'hFFFF);
    rd(`PMI_ADDR_PHY_CTRL, (cr & 16'hC790) | 16'h1008);
    // FIFO depth per code and mode
    for (int c = 0; c < 4; c++) begin
      wr(`PMI_ADDR_PHY_CTRL, {2'(c), 14'h0000});
      for (int m = 0; m < 4; m++) begin
        speed_is_1000 <= m[0];
        mac_if_gmii <= m[1];
        repeat (4) @(posedge clk_sys);
        chk(16'(tx_fifo_depth_q), (m == 3) ? depth(c) : 16'h0000);
      end
    end
    // Power-save codes with clock-disable both ways
    for (int c = 0; c < 8; c++) begin
      cr = {6'h00, 2'(c >> 1), 3'h0, c[0], 4'h0};
      wr(`PMI_ADDR_PHY_CTRL, cr);
      repeat (4) @(posedge clk_sys);
      chk(16'(pwr_q), 16'(exp_pwr(cr, 1'b0)));
    end
    // Active sleep: pulse spacing, then wake on partner
    wr(`PMI_ADDR_PHY_CTRL, 16'h0200);
    n = 0;
    repeat (PULSE * 3) begin
      @(posedge clk_sys);
      n += int'(link_pulse_q);
    end
    chk(16'(n), 16'h0003);
    partner_detect <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(16'(pwr_q), 16'h0000);
    rd(`PMI_ADDR_PHY_CTRL, 16'h1008);
    partner_detect <= 1'b0;
    // Forced link and deep power-down against both request sources
    for (int m = 0; m < 16; m++) begin
      cr = {5'h00, m[0], 2'b00, m[1], 7'h00};
      line_link_ok <= 1'($urandom);
      pd_pin <= m[2];
      bmc_pd <= m[3];
      wr(`PMI_ADDR_PHY_CTRL, cr);
      repeat (6) @(posedge clk_sys);
      chk(16'(link_good_q), 16'(m[0] | line_link_ok));
      chk(16'(pwr_q), 16'(exp_pwr(cr, m[2] | m[3])));
    end
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
